// ---- logic/psc_pkg.sv ----
// shared constants of the pattern-side channel interface
package psc_pkg;
  // =====================================================
  // structure
  localparam int NCH = 4;                    // channels
  localparam int NSLOT = 4;                  // edge slots per waveform
  localparam int WAVE_DEPTH = 256;           // waveforms per channel
  localparam int ENT_W = 16;                 // waveform entry width
  // =====================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;   // control
  localparam logic [7:0] OFS_TMU = 8'h04;    // measurement mux selects
  localparam logic [7:0] OFS_WADDR = 8'h08;  // waveform write pointer
  localparam logic [7:0] OFS_WDATA = 8'h0c;  // waveform write data
  localparam logic [7:0] OFS_ISTAT = 8'h10;  // sticky fail status
  localparam logic [7:0] OFS_IMASK = 8'h14;  // interrupt mask
  localparam logic [7:0] OFS_STATE = 8'h18;  // live comparator levels
  // =====================================================
  // control fields and reset values
  localparam int CTRL_LJ2 = 0;               // clock onto channel 2 drive
  localparam int CTRL_LJ3 = 1;               // clock onto channel 3 drive
  localparam int CTRL_DRV_OE = 2;            // enable drive pin pairs
  localparam logic [2:0] CTRL_RST = 3'h4;    // drive pairs on, no clock route
  localparam logic [11:0] TMU_RST = 12'h000; // all measurement outputs off
  localparam logic [3:0] IMASK_RST = 4'h0;   // all interrupts masked
  // =====================================================
  // measurement mux field layout: 3-bit source plus enable
  localparam int TMU_FLD_W = 4;              // field pitch
  localparam int TMU_EN_BIT = 3;             // enable bit inside a field
  localparam int WADDR_CH_LSB = 8;           // channel field of pointer
  // =====================================================
  // waveform entry layout, one bit per edge slot each
  localparam int ENT_DRV_LSB = 0;            // drive value
  localparam int ENT_EN_LSB = 4;             // drive enable
  localparam int ENT_EXP_LSB = 8;            // expected level
  localparam int ENT_STB_LSB = 12;           // compare strobe enable
  localparam logic [8:0] CNT_IDLE = 9'h1ff;  // counter parked, no edges
endpackage

// ---- logic/psc_channel.sv ----
// one formatter channel: waveform memory, edge placement and compare
`timescale 1ns/1ns
module psc_channel
  import psc_pkg::*;
(
  input wire logic clk,                   // master clock
  input wire logic rst,                   // sync reset, high
  input wire logic wave_we,               // write one waveform entry
  input wire logic [7:0] wave_idx,        // entry index to write
  input wire logic [ENT_W-1:0] wave_wdata, // entry contents
  input wire logic [7:0] waveform_select, // waveform address this cycle
  input wire logic tester_period_strobe,  // tester period start
  input wire logic compare_period_strobe, // compare period start
  input wire logic burst_active,          // pattern burst running
  input wire logic [7:0] global_delay,    // delay added to every edge
  input wire logic [3:0] fail_mask,       // per slot fail suppress
  input wire logic high_cmp,              // filtered high comparator
  input wire logic low_cmp,               // filtered low comparator
  output logic drive_val,                 // formatted drive value
  output logic drive_en,                  // formatted drive enable
  output logic [3:0] edge_fail_flags,     // slot 3 down to slot 0
  output logic [3:0] dut_capture_bits     // captured response
);
  // =====================================================
  // storage and timing state
  logic [ENT_W-1:0] wave_mem [0:WAVE_DEPTH-1]; // waveform table
  logic [ENT_W-1:0] entry;                // waveform of this period
  logic [8:0] tcnt;                       // cycles since tester period start
  logic [8:0] ccnt;                       // cycles since compare period start
  logic [7:0] delay_q;                    // sampled global delay
  logic [3:0] dfire;                      // drive slot fires now
  logic [3:0] cfire;                      // compare slot fires now
  logic [3:0] mism;                       // comparator disagrees with expect
  logic [3:0] next_fail;                  // fail flags for next cycle
  logic next_drive;                       // drive value at a firing slot
  logic next_den;                         // drive enable at a firing slot

  // table write port; contents undefined until software loads them
  always_ff @(posedge clk)
  begin
    if (wave_we)
      wave_mem[wave_idx] <= wave_wdata;
  end

  // the select is looked up once per tester period
  always_ff @(posedge clk)
  begin
    if (rst)
      entry <= '0;
    else if (tester_period_strobe)
      entry <= wave_mem[waveform_select];
  end

  // period counters; parked value never matches a slot
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tcnt <= CNT_IDLE;
      ccnt <= CNT_IDLE;
      delay_q <= 8'h00;
    end
    else
    begin
      delay_q <= global_delay;
      if (tester_period_strobe)
        tcnt <= 9'h000;
      else if (tcnt != CNT_IDLE)
        tcnt <= tcnt + 9'h001;
      if (compare_period_strobe)
        ccnt <= 9'h000;
      else if (ccnt != CNT_IDLE)
        ccnt <= ccnt + 9'h001;
    end
  end

  // per slot placement: slot k sits k cycles after the global delay
  genvar k;
  generate
    for (k = 0; k < NSLOT; k++)
    begin : g_slot
      assign dfire[k] = burst_active && (tcnt == ({1'b0, delay_q} + 9'(k)));
      assign cfire[k] = burst_active && (ccnt == ({1'b0, delay_q} + 9'(k)))
                        && entry[ENT_STB_LSB+k];
      // expect high needs high comparator, expect low needs low one clear
      assign mism[k] = entry[ENT_EXP_LSB+k] ? !high_cmp : low_cmp;
    end
  endgenerate

  // slots never coincide, so an or-reduce picks the firing one
  assign next_drive = |(dfire & entry[ENT_DRV_LSB +: NSLOT]);
  assign next_den = |(dfire & entry[ENT_EN_LSB +: NSLOT]);
  assign next_fail = cfire & mism & ~fail_mask;

  // drive state only moves at an edge; static outside bursts
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drive_val <= 1'b0;
      drive_en <= 1'b0;
    end
    else if (|dfire)
    begin
      drive_val <= next_drive;
      drive_en <= next_den;
    end
  end

  // fail pulses one cycle; capture holds until the slot strobes again
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      edge_fail_flags <= 4'h0;
      dut_capture_bits <= 4'h0;
    end
    else
    begin
      edge_fail_flags <= next_fail;
      dut_capture_bits <= (cfire & {NSLOT{high_cmp}}) | (dut_capture_bits & ~cfire);
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_lone_start;
    tester_period_strobe ##1 !tester_period_strobe;
  endsequence

  fail_needs_burst_a: assert property (|edge_fail_flags |-> $past(burst_active))
    else $error("fail flag outside a burst");
  mask_blocks_a: assert property ((edge_fail_flags & $past(fail_mask)) == 4'h0)
    else $error("masked slot reported a fail");
  idle_static_a: assert property (!burst_active |=> $stable(drive_val) && $stable(drive_en))
    else $error("drive moved while burst idle");
  period_count_a: assert property (s_lone_start |=> tcnt == 9'h001)
    else $error("tester period counter did not restart");
  edge_delay_a: assert property ($changed(drive_val) |-> $past(tcnt) >= {1'b0, $past(delay_q)})
    else $error("edge placed before the global delay");
  capture_bit_a: assert property (cfire[0] |=> dut_capture_bits[0] == $past(high_cmp))
    else $error("capture bit missed comparator level");
endmodule

// ---- logic/psc_pattern_side_channel_io.sv ----
// top of the pattern-side and pin-side interface of a four-channel formatter
//
// Notes on behaviour
// - mask bit k silences fails of slot k
// - per-channel 8-bit select addresses waveform table
// - per-channel 4-bit fail flags, slot 3 on top
// - per-channel 4 captured response bits, clocked out
// - no edges, static drive while burst idle, except channel 2/3 data carrying the clock
// - global 8-bit delay shifts every edge
// - measurement pairs float when not enabled
// - drive value as true and inverse legs
// - drive enable as true and inverse legs
// - low-jitter clock may replace channel 2/3 data
`timescale 1ns/1ns
module psc_pattern_side_channel_io
  import psc_pkg::*;
(
  input wire logic clk,                         // master clock, 20 MHz
  input wire logic rst,                         // sync reset, high
  // =====================================================
  // register bus
  input wire logic hsel,                        // slave select
  input wire logic [31:0] haddr,                // byte address
  input wire logic [1:0] htrans,                // transfer type
  input wire logic hwrite,                      // write when high
  input wire logic [2:0] hsize,                 // word only
  input wire logic [31:0] hwdata,               // write data
  input wire logic hready,                      // bus ready in
  output logic hreadyout,                       // always ready
  output logic hresp,                           // always okay
  output logic [31:0] hrdata,                   // read data
  // =====================================================
  // pattern side
  input wire logic [3:0] fail_mask,             // slot fail suppress
  input wire logic [NCH-1:0][7:0] waveform_select, // per channel
  input wire logic burst_active,                // burst running
  input wire logic tester_period_strobe,        // tester period start
  input wire logic compare_period_strobe,       // compare period start
  input wire logic [7:0] global_delay,          // shared edge delay
  output logic [NCH-1:0][3:0] edge_fail_flags,  // per channel fails
  output logic [NCH-1:0][3:0] dut_capture_bits, // per channel capture
  // =====================================================
  // pin side
  input wire logic [NCH-1:0] high_compare_in_p, // high comparator true
  input wire logic [NCH-1:0] high_compare_in_n, // high comparator inverse
  input wire logic [NCH-1:0] low_compare_in_p,  // low comparator true
  input wire logic [NCH-1:0] low_compare_in_n,  // low comparator inverse
  input wire logic low_jitter_clock_in_p,       // clean clock true
  input wire logic low_jitter_clock_in_n,       // clean clock inverse
  output logic [NCH-1:0] drive_value_out_p,     // drive data true
  output logic [NCH-1:0] drive_value_out_n,     // drive data inverse
  output logic [NCH-1:0] drive_value_out_oe,    // drive data enable
  output logic [NCH-1:0] drive_enable_out_p,    // driver on true
  output logic [NCH-1:0] drive_enable_out_n,    // driver on inverse
  output logic [NCH-1:0] drive_enable_out_oe,   // driver on enable
  output logic measure_arm_out_p,               // arm true
  output logic measure_arm_out_n,               // arm inverse
  output logic measure_arm_out_oe,              // arm pair enable
  output logic measure_start_out_p,             // start true
  output logic measure_start_out_n,             // start inverse
  output logic measure_start_out_oe,            // start pair enable
  output logic measure_stop_out_p,              // stop true
  output logic measure_stop_out_n,              // stop inverse
  output logic measure_stop_out_oe,             // stop pair enable
  output logic irq                              // level interrupt
);
  // =====================================================
  // bus phase tracking
  logic dp_we;                                  // write data phase pending
  logic [7:0] dp_addr;                          // address of that phase
  logic [31:0] rd_mux;                          // read value of haddr
  wire ap_valid = hsel && hready && htrans[1];  // accepted address phase

  // =====================================================
  // software state
  logic [2:0] ctrl;                             // control bits
  logic [11:0] tmu_sel;                         // three mux fields
  logic [9:0] waddr;                            // channel and entry index
  logic [ENT_W-1:0] wdata_last;                 // last entry written
  logic [3:0] istat;                            // sticky per-channel fails
  logic [3:0] imask;                            // interrupt enables

  // =====================================================
  // pin input synchronisers: high 0-3, low 4-7, clock 8
  logic [8:0] pin_raw;                          // decoded pair levels
  logic [8:0] sync1;                            // first stage only
  logic [8:0] sync2;                            // second stage
  logic [8:0] sync3;                            // third stage
  logic [8:0] pin_filt;                         // agreed levels

  // =====================================================
  // channel and output plumbing
  logic [NCH-1:0] drv_raw;                      // channel drive value
  logic [NCH-1:0] den_raw;                      // channel drive enable
  logic [NCH-1:0] next_dval;                    // value after clock route
  logic [NCH-1:0] ch_fail_any;                  // any slot failed
  logic [3:0] next_istat;                       // status after this cycle
  logic [7:0] cmp_src;                          // mux sources
  logic [2:0] next_meas;                        // selected mux levels
  logic [2:0] meas_en;                          // mux field enables
  logic [2:0] meas_p;                           // true legs
  logic [2:0] meas_n;                           // inverse legs
  logic [2:0] meas_oe;                          // pair enables

  // =====================================================
  // register decode
  wire wr_ctrl = dp_we && (dp_addr == OFS_CTRL);
  wire wr_tmu = dp_we && (dp_addr == OFS_TMU);
  wire wr_waddr = dp_we && (dp_addr == OFS_WADDR);
  wire wr_wdata = dp_we && (dp_addr == OFS_WDATA);
  wire wr_istat = dp_we && (dp_addr == OFS_ISTAT);
  wire wr_imask = dp_we && (dp_addr == OFS_IMASK);
  wire [7:0] ra = haddr[7:0];                   // upper bits alias
  wire lj_filt = pin_filt[8];                   // agreed clean clock

  // read mux; unmapped offsets read as zero
  assign rd_mux = (ra == OFS_CTRL) ? {29'h0, ctrl} :
                  (ra == OFS_TMU) ? {20'h0, tmu_sel} :
                  (ra == OFS_WADDR) ? {22'h0, waddr} :
                  (ra == OFS_WDATA) ? {16'h0, wdata_last} :
                  (ra == OFS_ISTAT) ? {28'h0, istat} :
                  (ra == OFS_IMASK) ? {28'h0, imask} :
                  (ra == OFS_STATE) ? {23'h0, pin_filt} : 32'h0;

  // a new fail in the clearing cycle survives the clear
  assign next_istat = (istat & ~(wr_istat ? hwdata[3:0] : 4'h0)) | ch_fail_any;

  // bus slave: zero wait states, read data registered at address phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dp_we <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      dp_we <= ap_valid && hwrite;
      dp_addr <= ra;
      if (ap_valid && !hwrite)
        hrdata <= rd_mux;
    end
  end

  // software registers; write data taken in the data phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= CTRL_RST;
      tmu_sel <= TMU_RST;
      waddr <= 10'h000;
      wdata_last <= '0;
      imask <= IMASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= hwdata[2:0];
      if (wr_tmu)
        tmu_sel <= hwdata[11:0];
      if (wr_waddr)
        waddr <= hwdata[9:0];
      if (wr_wdata)
        wdata_last <= hwdata[ENT_W-1:0];
      if (wr_imask)
        imask <= hwdata[3:0];
    end
  end

  // sticky status and interrupt; irq trails status by one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      istat <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      istat <= next_istat;
      irq <= |(istat & imask);
    end
  end

  // =====================================================
  // pin inputs: true leg high and inverse low reads one
  assign pin_raw = {low_jitter_clock_in_p & ~low_jitter_clock_in_n,
                    low_compare_in_p & ~low_compare_in_n,
                    high_compare_in_p & ~high_compare_in_n};

  // three stages; a level counts once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
      sync3 <= 9'h000;
      pin_filt <= 9'h000;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_filt <= (sync2 & sync3) | (pin_filt & (sync2 ^ sync3));
    end
  end

  // =====================================================
  // channels, drive legs and clock routing
  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      wire wave_we = wr_wdata && (waddr[WADDR_CH_LSB +: 2] == 2'(c));
      // only channels 2 and 3 can carry the clean clock
      wire lj_sel = ((c == 2) && ctrl[CTRL_LJ2]) || ((c == 3) && ctrl[CTRL_LJ3]);

      psc_channel u_ch (
        .clk(clk),
        .rst(rst),
        .wave_we(wave_we),
        .wave_idx(waddr[7:0]),
        .wave_wdata(hwdata[ENT_W-1:0]),
        .waveform_select(waveform_select[c]),
        .tester_period_strobe(tester_period_strobe),
        .compare_period_strobe(compare_period_strobe),
        .burst_active(burst_active),
        .global_delay(global_delay),
        .fail_mask(fail_mask),
        .high_cmp(pin_filt[c]),
        .low_cmp(pin_filt[NCH+c]),
        .drive_val(drv_raw[c]),
        .drive_en(den_raw[c]),
        .edge_fail_flags(edge_fail_flags[c]),
        .dut_capture_bits(dut_capture_bits[c])
      );

      assign next_dval[c] = lj_sel ? lj_filt : drv_raw[c];
      assign ch_fail_any[c] = |edge_fail_flags[c];
    end
  endgenerate

  // complementary legs registered so both switch together
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drive_value_out_p <= '0;
      drive_value_out_n <= '1;
      drive_value_out_oe <= '0;
      drive_enable_out_p <= '0;
      drive_enable_out_n <= '1;
      drive_enable_out_oe <= '0;
    end
    else
    begin
      drive_value_out_p <= next_dval;
      drive_value_out_n <= ~next_dval;
      drive_value_out_oe <= {NCH{ctrl[CTRL_DRV_OE]}};
      drive_enable_out_p <= den_raw;
      drive_enable_out_n <= ~den_raw;
      drive_enable_out_oe <= {NCH{ctrl[CTRL_DRV_OE]}};
    end
  end

  // =====================================================
  // measurement muxes: sources high 0-3 then low 0-3
  assign cmp_src = pin_filt[7:0];

  genvar m;
  generate
    for (m = 0; m < 3; m++)
    begin : g_meas
      assign next_meas[m] = cmp_src[tmu_sel[m*TMU_FLD_W +: 3]];
      assign meas_en[m] = tmu_sel[m*TMU_FLD_W+TMU_EN_BIT];
    end
  endgenerate

  // a disabled pair releases both legs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meas_p <= 3'h0;
      meas_n <= 3'h7;
      meas_oe <= 3'h0;
    end
    else
    begin
      meas_p <= next_meas;
      meas_n <= ~next_meas;
      meas_oe <= meas_en;
    end
  end

  assign measure_arm_out_p = meas_p[0];
  assign measure_arm_out_n = meas_n[0];
  assign measure_arm_out_oe = meas_oe[0];
  assign measure_start_out_p = meas_p[1];
  assign measure_start_out_n = meas_n[1];
  assign measure_start_out_oe = meas_oe[1];
  assign measure_stop_out_p = meas_p[2];
  assign measure_stop_out_n = meas_n[2];
  assign measure_stop_out_oe = meas_oe[2];

  // =====================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  drive_pair_a: assert property (drive_value_out_n == ~drive_value_out_p)
    else $error("drive data legs not complementary");
  enable_pair_a: assert property (drive_enable_out_n == ~drive_enable_out_p)
    else $error("drive enable legs not complementary");
  arm_float_a: assert property (!tmu_sel[TMU_EN_BIT] |=> !measure_arm_out_oe)
    else $error("arm pair driven while disabled");
  clock_route_a: assert property (ctrl[CTRL_LJ2] |=> drive_value_out_p[2] == $past(lj_filt))
    else $error("clean clock not routed to channel 2");
  fail_sticky_a: assert property (ch_fail_any[0] |=> istat[0])
    else $error("channel 0 fail not recorded");
  irq_level_a: assert property (|(istat & imask) |=> irq)
    else $error("interrupt missing for unmasked status");
endmodule

// ---- tb/psc_dcl_model.sv ----
// far-side comparator chips: differential level pairs per channel
`timescale 1ns/1ns
module psc_dcl_model
(
  input wire logic [3:0] above_high, // dut above high threshold
  input wire logic [3:0] above_low,  // dut above low threshold
  output logic [3:0] hi_p,           // high pair true leg
  output logic [3:0] hi_n,           // high pair inverse leg
  output logic [3:0] lo_p,           // low pair true leg
  output logic [3:0] lo_n            // low pair inverse leg
);
  // =====================================================
  // comparators follow the dut level at all times, never released
  assign hi_p = above_high;
  assign hi_n = ~above_high;
  assign lo_p = above_low;
  assign lo_n = ~above_low;
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the pattern-side channel interface
`timescale 1ns/1ns
module testbench;
  import psc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, burst_active = 1'b0, t_strobe = 1'b0, c_strobe = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [3:0] fail_mask = 4'h0, hi_p, hi_n, lo_p, lo_n;
  logic [NCH-1:0][7:0] waveform_select = {4{8'h00}};
  logic [NCH-1:0][3:0] edge_fail_flags;
  logic [15:0] acc;
  int first;
  logic [7:0] gdelay = 8'h02;
  logic [3:0] hi_lvl = 4'h0;
  logic [NCH-1:0][3:0] capt;
  logic [NCH-1:0] dv_p, dv_n, dv_oe, de_p, de_n, de_oe;
  logic hreadyout, hresp, arm_oe, stop_oe, stop_p, stop_n, irq;
  int n_errors = 0, num_checks = 0;
  always #25 clk = ~clk;
  // dut sits between thresholds: high pair reads 0, low pair reads 1
  psc_dcl_model psc_dcl_model_inst (.above_high(hi_lvl), .above_low(4'hf), .hi_p(hi_p), .hi_n(hi_n), .lo_p(lo_p),
    .lo_n(lo_n));
  psc_pattern_side_channel_io psc_pattern_side_channel_io_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .fail_mask(fail_mask), .waveform_select(waveform_select),
    .burst_active(burst_active), .tester_period_strobe(t_strobe), .compare_period_strobe(c_strobe),
    .global_delay(gdelay), .edge_fail_flags(edge_fail_flags), .dut_capture_bits(capt), .high_compare_in_p(hi_p),
    .high_compare_in_n(hi_n),
    .low_compare_in_p(lo_p), .low_compare_in_n(lo_n), .low_jitter_clock_in_p(1'b0), .low_jitter_clock_in_n(1'b1),
    .drive_value_out_p(dv_p), .drive_value_out_n(dv_n), .drive_value_out_oe(dv_oe), .drive_enable_out_p(de_p),
    .drive_enable_out_n(de_n), .drive_enable_out_oe(de_oe), .measure_arm_out_p(), .measure_arm_out_n(),
    .measure_arm_out_oe(arm_oe), .measure_start_out_p(), .measure_start_out_n(), .measure_start_out_oe(),
    .measure_stop_out_p(stop_p), .measure_stop_out_n(stop_n), .measure_stop_out_oe(stop_oe), .irq(irq));
  // =====================================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // bounded wait for ready; a hang ends the run
  task automatic wait_rdy();
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1)
    begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  // one single-word transfer; idle goes out in the data phase so nothing is set twice per step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // pulse both period strobes, then gather every fail pulse seen
  task automatic collect();
    acc = 16'h0;
    first = 0;
    t_strobe <= 1'b1;
    c_strobe <= 1'b1;
    @(posedge clk);
    t_strobe <= 1'b0;
    c_strobe <= 1'b0;
    // first records the edge count at which a fail pulse is first seen
    for (int n = 1; n <= 14; n++)
    begin
      @(posedge clk);
      acc = acc | edge_fail_flags;
      if (first == 0 && edge_fail_flags != '0)
        first = n;
    end
  endtask
  // =====================================================
  // scenarios
  task automatic s_reset();
    chk({dv_p, dv_n, de_p, de_n}, 32'h0f0f);
    chk({arm_oe, stop_oe}, 32'h0);
    chk({hresp, de_oe}, 32'h0);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rd, {29'h0, CTRL_RST});
    bus(1'b0, OFS_IMASK, 32'h0);
    chk(rd, {28'h0, IMASK_RST});
    bus(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
  endtask
  // all slots mismatch; mask 0101 must leave slots 3 and 1 only
  task automatic s_burst();
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, OFS_WADDR, {22'h0, i[1:0], i[2] ? 8'h06 : 8'h05});
      bus(1'b1, OFS_WDATA, i[2] ? 32'hff00 : 32'hfff8);
    end
    fail_mask <= 4'h5;
    waveform_select <= {4{8'h05}};
    burst_active <= 1'b1;
    collect();
    chk(acc, 32'haaaa);
    chk(first, 32'd5);
    chk({dv_p, dv_n, de_p, de_n, dv_oe, de_oe}, 32'hf0f0ff);
    bus(1'b0, OFS_ISTAT, 32'h0);
    chk(rd, 32'hf);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IMASK, 32'hf);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_ISTAT, 32'hf);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  // idle burst: a new waveform with drive 0 must change nothing
  task automatic s_idle();
    burst_active <= 1'b0;
    waveform_select <= {4{8'h06}};
    collect();
    chk(acc, 32'h0);
    chk({dv_p, dv_n, de_p, de_n}, 32'hf0f0);
  endtask
  // stop pair enabled onto low comparator of channel 0, arm left floating
  task automatic s_tmu();
    bus(1'b1, OFS_TMU, 32'hc00);
    repeat (3) @(posedge clk);
    chk({arm_oe, stop_oe, stop_p, stop_n}, 32'h6);
  endtask
  // dut above both thresholds: no fails, every compare slot captures a one
  task automatic s_match();
    hi_lvl <= 4'hf;
    burst_active <= 1'b1;
    waveform_select <= {4{8'h05}};
    // let the comparator level pass the pin filter first
    repeat (6) @(posedge clk);
    collect();
    chk(acc, 32'h0);
    chk(capt, 32'hffff);
  endtask
  // clean clock, held low, replaces drive data of channels 2 and 3
  task automatic s_route();
    bus(1'b1, OFS_CTRL, 32'h7);
    repeat (2) @(posedge clk);
    chk({dv_p, dv_n, dv_oe}, 32'h3cf);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_burst();
    s_idle();
    s_tmu();
    s_match();
    s_route();
    tally_and_finish();
  end
endmodule
